// ---- dv/rtsl_host.sv ----
// Host model: Wishbone classic master that programs the ramp tail registers
`timescale 1ns/1ps
module rtsl_host (
  input  wire logic        clk,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      dat,
  input  wire logic [31:0] rdat,
  input  wire logic        ack
);
  // Idle bus at time zero
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we  = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h00000000;
  end
  ////////////////////////////////////////
  // One classic cycle, held until ack is sampled; only the bench watchdog ends a wait on a dead slave
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx[5:0], 2'b00};
    sel <= s;
    dat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    // Released lines show inverted values so no stale word is mistaken for a live one
    adr <= ~adr;
    dat <= ~d;
  endtask
endmodule

// ---- dv/rtsl_ramp_tail_bench.sv ----
// Self-checking bench for the ramp tail block
`timescale 1ns/1ps
`include "rtsl_params.svh"
module rtsl_ramp_tail_bench;
  logic        clk, reset, cyc, stb, we, ack;         // Clock, reset, bus strobes
  logic        leftPin, rightPin, sdMode, lcEnable;   // Pins driven in the motor's place
  logic        commValid, commDir;                    // Commutation step source
  logic        stepPulse, stepDir, lcActive;          // Motor side outputs
  logic [7:0]  adr;                                   // Byte address
  logic [3:0]  sel;                                   // Byte lanes
  logic [31:0] wdat, rdat, encPos, rdVal;             // Bus data, encoder, last read
  int          badCount, nTests, stepCnt, stepPos;    // Tallies
  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  rtsl_host host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(wdat),
                  .rdat(rdat), .ack(ack));
  rtsl_ramp_tail dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .refLeftPin(leftPin), .refRightPin(rightPin), .stepDirMode(sdMode),
    .loadCommutationEnableInput(lcEnable), .commStepValid(commValid), .commStepDir(commDir),
    .encoderPosition(encPos), .stepPulse(stepPulse), .stepDir(stepDir), .loadCommutationActive(lcActive));
  // Step tally; direction high means negative
  always @(posedge clk) begin
    if (stepPulse === 1'b1) begin
      stepCnt <= stepCnt + 1;
      stepPos <= (stepDir === 1'b1) ? stepPos - 1 : stepPos + 1;
    end
  end
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, idx, 4'hf, d, q);
  endtask
  task automatic rd(input logic [7:0] idx);
    host.xfer(1'b0, idx, 4'hf, 32'h0, rdVal);
  endtask
  // Counts edges until a step pulse (or the limit)
  task automatic waitStep(input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (stepPulse !== 1'b1 && n < lim);
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic close_out;
    if (badCount == 0 && nTests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  // Register access kinds, refusals and hold mode
  task automatic t_regs;
    wr(`RTSL_IDX_MODE, 32'h3);
    rd(`RTSL_IDX_MODE);
    check(rdVal, 32'h3);
    rd(`RTSL_IDX_STOPV);
    check(rdVal, 32'h0);
    wr(`RTSL_IDX_TARGET, 32'h89abcdef);
    rd(`RTSL_IDX_TARGET);
    check(rdVal, 32'h89abcdef);
    host.xfer(1'b1, `RTSL_IDX_TARGET, 4'h3, 32'h0, rdVal);
    rd(`RTSL_IDX_TARGET);
    check(rdVal, 32'h89abcdef);
    wr(`RTSL_IDX_ENCPOS, 32'hffffffff);
    rd(`RTSL_IDX_ENCPOS);
    check(rdVal, 32'h0);
    settle(200);
    check(32'(stepCnt), 32'h0);
  endtask
  // Positioning across the wrap point, then the zero wait
  task automatic t_move;
    int c0, p0, n, tw;
    bit seen, done;
    wr(`RTSL_IDX_START, 32'h3ffff);
    wr(`RTSL_IDX_STOPV, 32'h3ffff);
    wr(`RTSL_IDX_PHASEV, 32'h0);
    wr(`RTSL_IDX_DMAIN, 32'hffff);
    wr(`RTSL_IDX_DFINAL, 32'hffff);
    wr(`RTSL_IDX_ZWAIT, 32'h2);
    wr(`RTSL_IDX_CURPOS, 32'hfffffffe);
    wr(`RTSL_IDX_TARGET, 32'hfffffffe);
    wr(`RTSL_IDX_MODE, 32'h0);
    wr(`RTSL_IDX_STAT, 32'h80);
    c0 = stepCnt;
    p0 = stepPos;
    wr(`RTSL_IDX_TARGET, 32'h1);
    seen = 1'b0;
    done = 1'b0;
    n = 0;
    tw = 0;
    while (!done && n < 4000) begin
      rd(`RTSL_IDX_STAT);
      n++;
      if (!seen && rdVal[`RTSL_ST_ZWAIT]) begin
        seen = 1'b1;
        tw = n;
      end
      else if (seen && !rdVal[`RTSL_ST_ZWAIT]) done = 1'b1;
    end
    // Each poll is three cycles, so the wait is judged to within a few polls
    check({31'h0, (n - tw) * 3 >= 2 * `RTSL_ZWAIT_UNIT - 9 && (n - tw) * 3 <= 2 * `RTSL_ZWAIT_UNIT + 9}, 32'h1);
    check(32'(stepCnt - c0), 32'h3);
    check(32'(stepPos - p0), 32'h3);
    rd(`RTSL_IDX_CURPOS);
    check(rdVal, 32'h1);
    rd(`RTSL_IDX_STAT);
    check({29'h0, rdVal[`RTSL_ST_STANDSTILL], rdVal[`RTSL_ST_REACHED], rdVal[`RTSL_ST_POSREACH]}, 32'h7);
    wr(`RTSL_IDX_STAT, 32'h80);
    rd(`RTSL_IDX_STAT);
    check({31'h0, rdVal[`RTSL_ST_POSREACH]}, 32'h0);
  endtask
  // Switch events latch motor and encoder positions
  task automatic t_latch;
    wr(`RTSL_IDX_SWCFG, 32'h320);
    rd(`RTSL_IDX_SWCFG);
    check(rdVal, 32'h320);
    encPos <= 32'h5a5a0001;
    leftPin <= 1'b1;
    settle(12);
    rd(`RTSL_IDX_LATCH);
    check(rdVal, 32'h1);
    rd(`RTSL_IDX_ENCLATCH);
    check(rdVal, 32'h5a5a0001);
    rd(`RTSL_IDX_STAT);
    check({30'h0, rdVal[`RTSL_ST_LATR], rdVal[`RTSL_ST_LATL]}, 32'h1);
    wr(`RTSL_IDX_STAT, 32'h4);
    leftPin <= 1'b0;
    rightPin <= 1'b1;
    settle(12);
    rd(`RTSL_IDX_STAT);
    check({30'h0, rdVal[`RTSL_ST_LATR], rdVal[`RTSL_ST_LATL]}, 32'h0);
    encPos <= 32'h0000a5a5;
    rightPin <= 1'b0;
    settle(12);
    rd(`RTSL_IDX_STAT);
    check({31'h0, rdVal[`RTSL_ST_LATR]}, 32'h1);
    rd(`RTSL_IDX_ENCLATCH);
    check(rdVal, 32'h0000a5a5);
  endtask
  // Velocity modes, step rate and load commutation switching
  task automatic t_vel;
    int n;
    logic [31:0] p;
    wr(`RTSL_IDX_LCMIN, 32'h100);
    sdMode <= 1'b1;
    lcEnable <= 1'b1;
    settle(5);
    check({31'h0, lcActive}, 32'h1);
    @(posedge clk);
    lcEnable <= 1'b0;
    settle(5);
    check({31'h0, lcActive}, 32'h0);
    @(posedge clk);
    sdMode <= 1'b0;
    wr(`RTSL_IDX_SWCFG, 32'h0);
    wr(`RTSL_IDX_LCMIN, 32'h0);
    wr(`RTSL_IDX_MODE, 32'h1);
    waitStep(4000, n);
    check({31'h0, n < 4000}, 32'h1);
    check({31'h0, stepDir}, 32'h0);
    waitStep(400, n);
    // Start velocity 0x3ffff gives one step per 2^24/0x3ffff, about 64 clocks
    check({31'h0, n >= 62 && n <= 66}, 32'h1);
    check({31'h0, lcActive}, 32'h0);
    wr(`RTSL_IDX_MODE, 32'h2);
    n = 0;
    while (!(stepPulse === 1'b1 && stepDir === 1'b1) && n < 30000) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, stepDir}, 32'h1);
    wr(`RTSL_IDX_MODE, 32'h3);
    waitStep(400, n);
    check({31'h0, stepDir}, 32'h1);
    wr(`RTSL_IDX_SWCFG, 32'h400);
    wr(`RTSL_IDX_LCMIN, 32'h1);
    settle(2);
    check({31'h0, lcActive}, 32'h1);
    // Commutation steps now drive the position counter
    rd(`RTSL_IDX_CURPOS);
    p = rdVal;
    commDir <= 1'b0;
    commValid <= 1'b1;
    repeat (3) @(posedge clk);
    commValid <= 1'b0;
    rd(`RTSL_IDX_CURPOS);
    check(rdVal, p + 32'h3);
  endtask
  ////////////////////////////////////////
  // Reset, then the scenarios in turn
  initial begin
    reset = 1'b1;
    leftPin = 1'b0;
    rightPin = 1'b0;
    sdMode = 1'b0;
    lcEnable = 1'b0;
    commValid = 1'b0;
    commDir = 1'b0;
    encPos = 32'h0;
    badCount = 0;
    nTests = 0;
    stepCnt = 0;
    stepPos = 0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_move();
    t_latch();
    t_vel();
    close_out();
  end
  // Watchdog sized well above the longest expected run
  initial begin
    repeat (90000) @(posedge clk);
    badCount++;
    close_out();
  end
endmodule

// ---- src/rtsl_params.svh ----
// Register offsets, field positions, reset values and timing counts of the ramp tail block
`ifndef RTSL_PARAMS_SVH
`define RTSL_PARAMS_SVH
// Printed register indices; byte address is four times the index
`define RTSL_IDX_MODE      8'h20
`define RTSL_IDX_CURPOS    8'h21
`define RTSL_IDX_ACTVEL    8'h22
`define RTSL_IDX_START     8'h23
`define RTSL_IDX_PHASEV    8'h25
`define RTSL_IDX_DMAIN     8'h28
`define RTSL_IDX_DFINAL    8'h2a
`define RTSL_IDX_STOPV     8'h2b
`define RTSL_IDX_ZWAIT     8'h2c
`define RTSL_IDX_TARGET    8'h2d
`define RTSL_IDX_LCMIN     8'h33
`define RTSL_IDX_SWCFG     8'h34
`define RTSL_IDX_STAT      8'h35
`define RTSL_IDX_LATCH     8'h36
`define RTSL_IDX_ENCLATCH  8'h37
`define RTSL_IDX_ENCPOS    8'h38
// Reset values
`define RTSL_STOPV_RST     18'h00001
// Switch configuration field positions
`define RTSL_SW_POLL       2
`define RTSL_SW_POLR       3
`define RTSL_SW_LAT_LA     5
`define RTSL_SW_LAT_LI     6
`define RTSL_SW_LAT_RA     7
`define RTSL_SW_LAT_RI     8
`define RTSL_SW_ENCLAT     9
// Status field positions
`define RTSL_ST_LATL       2
`define RTSL_ST_LATR       3
`define RTSL_ST_REACHED    9
`define RTSL_ST_POSREACH   7
`define RTSL_ST_ZWAIT      8
`define RTSL_ST_STANDSTILL 10
`define RTSL_ST_W1C_MASK   14'h008c
// Timing: wait unit in clocks, velocity and acceleration time bases
`define RTSL_ZWAIT_UNIT    512
`define RTSL_VEL_TBASE_LOG2 24
`define RTSL_ACC_TBASE_LOG2 41
`endif

// ---- src/rtsl_pkg.sv ----
// Types shared by the ramp tail block
package rtsl_pkg;
  // Motion profile selector codes
  typedef enum logic [1:0] {
    RTSL_POSITION = 2'h0,
    RTSL_VEL_POS  = 2'h1,
    RTSL_VEL_NEG  = 2'h2,
    RTSL_HOLD     = 2'h3
  } rtsl_mode_t;
  // Reference switch pair after synchronisation
  typedef struct packed {
    logic left;
    logic right;
  } rtsl_sw_t;
  // Ramp states, one-hot
  typedef enum logic [3:0] {
    RTSL_IDLE  = 4'h1,
    RTSL_ACCEL = 4'h2,
    RTSL_DECEL = 4'h4,
    RTSL_ZWAIT = 4'h8
  } rtsl_state_t;
endpackage

// ---- src/rtsl_ramp_tail.sv ----
// Ramp generator tail: stop velocity, zero wait, target move, load commutation, position latch
`timescale 1ns/1ps
`include "rtsl_params.svh"
////////////////////////////////////////////////////////////////////////////////
// Contract
// [R1] 18-bit stop velocity, reset value one
// [R2] Software never programs zero stop velocity
// [R3] Software keeps stop velocity above start velocity; the bench writes both as 0x3ffff
// [R4] Wait count times 512 clocks after stop
// [R5] Target write starts positioning move
// [R6] Software sets ramp parameters before target
// [R7] Position wraps modulo two to 32
// [R8] Target rewrite re-accelerates after parameter raise
// [R9] Load commutation above minimum, or enable input
// [R10] Zero minimum velocity disables load commutation
// [R11] Commutation position written to current position
// [R12] Heavy load never steps below minimum
// [R13] Software enables stall stop with commutation
// [R14] Latch current position on selected switch event
// [R15] Encoder position latched on same event
// [R16] 14-bit status readable, event flags write-clear
// [R17] Velocity unit is two^24 clocks
// [R18] Acceleration unit is two^41 over clock squared
// [R19] Selector: position, plus, minus, hold
// [R20] Move done at target with zero velocity
// [R21] Parameter writes apply next update, read zero
module rtsl_ramp_tail #(
  parameter int MAX_VEL = 23'h7ffe00 // Velocity clamp
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        refLeftPin,
  input  wire logic        refRightPin,
  input  wire logic        stepDirMode,
  input  wire logic        loadCommutationEnableInput,
  input  wire logic        commStepValid,
  input  wire logic        commStepDir,
  input  wire logic [31:0] encoderPosition,
  output logic             stepPulse,
  output logic             stepDir,
  output logic             loadCommutationActive
);
  ////////////////////////////////////////////////////////////////////////////////
  // Register bus decode
  logic        ackFf;                  // One-cycle answer
  logic [31:0] rdDataFf;               // Registered read data
  wire  [7:0]  regIdx   = {2'h0, wb_adr_i[7:2]} | 8'h20; // Index in upper window
  wire         busReq   = wb_cyc_i & wb_stb_i & ~ackFf;
  wire         wrAll    = busReq & wb_we_i & (wb_sel_i == 4'hf);
  wire         wrMode   = wrAll & (regIdx == `RTSL_IDX_MODE);
  wire         wrCurPos = wrAll & (regIdx == `RTSL_IDX_CURPOS);
  wire         wrStart  = wrAll & (regIdx == `RTSL_IDX_START);
  wire         wrPhaseV = wrAll & (regIdx == `RTSL_IDX_PHASEV);
  wire         wrDmain  = wrAll & (regIdx == `RTSL_IDX_DMAIN);
  wire         wrDfinal = wrAll & (regIdx == `RTSL_IDX_DFINAL);
  wire         wrStopV  = wrAll & (regIdx == `RTSL_IDX_STOPV);
  wire         wrZwait  = wrAll & (regIdx == `RTSL_IDX_ZWAIT);
  wire         wrTarget = wrAll & (regIdx == `RTSL_IDX_TARGET);
  wire         wrLcMin  = wrAll & (regIdx == `RTSL_IDX_LCMIN);
  wire         wrSwCfg  = wrAll & (regIdx == `RTSL_IDX_SWCFG);
  wire         wrStat   = wrAll & (regIdx == `RTSL_IDX_STAT);

  ////////////////////////////////////////////////////////////////////////////////
  // Parameter registers
  rtsl_pkg::rtsl_mode_t modeFf;        // Motion profile select
  logic [31:0] curPosFf;               // Current position
  logic [31:0] targetFf;               // Target position
  logic [17:0] startVelFf;             // Start velocity
  logic [19:0] phaseVelFf;             // Phase threshold velocity
  logic [15:0] dMainFf;                // Main deceleration
  logic [15:0] dFinalFf;               // Final deceleration
  logic [17:0] stopVelFf;              // Stop velocity
  logic [15:0] zWaitFf;                // Zero velocity wait count
  logic [22:0] lcMinFf;                // Load commutation minimum velocity
  logic [11:0] swCfgFf;                // Switch configuration
  logic [31:0] latchFf;                // Latched position
  logic [31:0] encLatchFf;             // Latched encoder position
  logic        posStatFf;              // Position reached sticky flag
  logic [1:0]  latStatFf;              // Latch event flags {right,left}
  logic        reachedFf;              // Reached-target level

  // Parameter writes; write-only ones are sampled by the ramp each update
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      modeFf     <= rtsl_pkg::RTSL_POSITION;
      startVelFf <= 18'h0;
      phaseVelFf <= 20'h0;
      dMainFf    <= 16'h0;
      dFinalFf   <= 16'h0;
      stopVelFf  <= `RTSL_STOPV_RST; // R1
      zWaitFf    <= 16'h0;
      targetFf   <= 32'h0;
      lcMinFf    <= 23'h0;
      swCfgFf    <= 12'h0;
    end else begin
      if (wrMode)   modeFf     <= rtsl_pkg::rtsl_mode_t'(wb_dat_i[1:0]); // R19
      if (wrStart)  startVelFf <= wb_dat_i[17:0];
      if (wrPhaseV) phaseVelFf <= wb_dat_i[19:0];
      if (wrDmain)  dMainFf    <= wb_dat_i[15:0];
      if (wrDfinal) dFinalFf   <= wb_dat_i[15:0];
      if (wrStopV)  stopVelFf  <= wb_dat_i[17:0]; // R1
      if (wrZwait)  zWaitFf    <= wb_dat_i[15:0];
      if (wrTarget) targetFf   <= wb_dat_i;       // R5
      if (wrLcMin)  lcMinFf    <= wb_dat_i[22:0];
      if (wrSwCfg)  swCfgFf    <= wb_dat_i[11:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Velocity time base: one update every 2^24/2^24 clocks would be too coarse;
  // velocity is accumulated into a 24-bit phase each clock so that v steps
  // occur per 2^24 clocks. Acceleration adds once per 2^17 clocks, giving 2^41.
  localparam int ACC_DIV_LOG2 = `RTSL_ACC_TBASE_LOG2 - `RTSL_VEL_TBASE_LOG2;
  logic [ACC_DIV_LOG2-1:0] accDivFf;   // Acceleration enable divider
  logic [23:0] phaseAccFf;             // Step phase accumulator
  logic [22:0] velFf;                  // Ramp velocity magnitude
  logic        dirFf;                  // Direction, 1 is negative
  logic [25:0] waitCntFf;              // Zero wait counter in clocks
  rtsl_pkg::rtsl_state_t stateFf;      // Ramp state
  wire         accTick  = (accDivFf == 17'h0);  // R18
  wire  [24:0] phaseSum = {1'b0, phaseAccFf} + {2'h0, velFf}; // R17
  wire         rampStep = phaseSum[24];
  wire  [31:0] distance = targetFf - curPosFf;   // R7
  wire         wantNeg  = distance[31];
  wire  [31:0] absDist  = wantNeg ? (32'h0 - distance) : distance;
  wire         atTarget = (distance == 32'h0);
  // Mode and enable pins come from outside; three stages, a change counts once stages two and three agree
  logic [1:0]  dc1Ff, dc2Ff, dc3Ff;    // {stepDirMode, enable} synchroniser stages
  logic [1:0]  dcStFf;                 // Accepted pin levels
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dc1Ff  <= 2'h0;
      dc2Ff  <= 2'h0;
      dc3Ff  <= 2'h0;
      dcStFf <= 2'h0;
    end else begin
      dc1Ff  <= {stepDirMode, loadCommutationEnableInput};
      dc2Ff  <= dc1Ff;
      dc3Ff  <= dc2Ff;
      dcStFf <= ((dc2Ff ~^ dc3Ff) & dc3Ff) | ((dc2Ff ^ dc3Ff) & dcStFf);
    end
  end
  // Load commutation gating; zero minimum disables it entirely, even under external step/dir
  wire         lcOn     = (lcMinFf != 23'h0) &&
                          (dcStFf[1] ? dcStFf[0] : (velFf >= lcMinFf)); // R9 R10
  // Decel when remaining distance is no more than velocity in steps-ish units
  wire         mustStop = (absDist[31:8] <= {9'h0, velFf[22:8]}) || (wantNeg != dirFf);
  wire  [22:0] decStep  = (velFf > {3'h0, phaseVelFf}) ? {7'h0, dMainFf} : {7'h0, dFinalFf};
  wire  [22:0] floorVel = (lcOn && lcMinFf > {5'h0, stopVelFf}) ? lcMinFf : {5'h0, stopVelFf}; // R12

  // Ramp state machine
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stateFf    <= rtsl_pkg::RTSL_IDLE;
      velFf      <= 23'h0;
      dirFf      <= 1'b0;
      waitCntFf  <= 26'h0;
      accDivFf   <= 17'h0;
      phaseAccFf <= 24'h0;
    end else begin
      accDivFf   <= accDivFf + 17'h1;
      phaseAccFf <= phaseSum[23:0];
      case (stateFf)
        rtsl_pkg::RTSL_IDLE: begin
          // Start a move when not at target in positioning, or always in velocity modes
          if ((modeFf == rtsl_pkg::RTSL_POSITION && !atTarget) ||
              modeFf == rtsl_pkg::RTSL_VEL_POS || modeFf == rtsl_pkg::RTSL_VEL_NEG) begin // R5 R19
            stateFf <= rtsl_pkg::RTSL_ACCEL;
            velFf   <= {5'h0, startVelFf};
            dirFf   <= (modeFf == rtsl_pkg::RTSL_POSITION) ? wantNeg : (modeFf == rtsl_pkg::RTSL_VEL_NEG);
          end
        end
        rtsl_pkg::RTSL_ACCEL: begin
          // Hold keeps velocity; positioning brakes near target
          // A velocity mode whose sign flips brakes first, then reverses after the zero wait
          if ((modeFf == rtsl_pkg::RTSL_POSITION && mustStop) ||
              (modeFf == rtsl_pkg::RTSL_VEL_POS && dirFf) ||
              (modeFf == rtsl_pkg::RTSL_VEL_NEG && !dirFf)) begin // R19
            stateFf <= rtsl_pkg::RTSL_DECEL;
          end else if (accTick && modeFf != rtsl_pkg::RTSL_HOLD && velFf < MAX_VEL[22:0]) begin
            velFf <= velFf + 23'h1;
          end
        end
        rtsl_pkg::RTSL_DECEL: begin
          // A target rewrite after raising limits re-enters acceleration
          if (wrTarget) begin
            stateFf <= rtsl_pkg::RTSL_ACCEL; // R8
          end else if (velFf <= floorVel) begin
            // Positioning keeps the floor velocity until the target is reached or passed
            if (modeFf != rtsl_pkg::RTSL_POSITION || atTarget || wantNeg != dirFf) begin // R20
              velFf     <= 23'h0;
              stateFf   <= rtsl_pkg::RTSL_ZWAIT;
              waitCntFf <= {zWaitFf, 9'h0} + 26'h0; // R4
            end
          end else if (accTick) begin
            // Never brake below the floor, or a move could stall short of its target
            velFf <= (velFf - floorVel > decStep) ? velFf - decStep : floorVel;
          end
        end
        rtsl_pkg::RTSL_ZWAIT: begin
          // No new motion or reversal until the wait expires
          if (waitCntFf == 26'h0) begin
            stateFf <= rtsl_pkg::RTSL_IDLE; // R4
          end else begin
            waitCntFf <= waitCntFf - 26'h1;
          end
        end
        default: stateFf <= rtsl_pkg::RTSL_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Position counter, commutation feedback, step outputs
  wire stepNow = lcOn ? commStepValid : rampStep;
  wire stepNeg = lcOn ? commStepDir : dirFf;
  // In positioning mode no step once the position equals the target, so a move cannot overshoot by one
  wire stepGo  = stepNow && stateFf != rtsl_pkg::RTSL_ZWAIT && stateFf != rtsl_pkg::RTSL_IDLE &&
                 !(modeFf == rtsl_pkg::RTSL_POSITION && atTarget); // R20
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      curPosFf  <= 32'h0;
      stepPulse <= 1'b0;
      stepDir   <= 1'b0;
    end else begin
      stepPulse <= stepGo;
      stepDir   <= stepNeg;
      if (wrCurPos) begin
        curPosFf <= wb_dat_i;
      end else if (stepGo) begin
        curPosFf <= stepNeg ? curPosFf - 32'h1 : curPosFf + 32'h1; // R7 R11
      end
    end
  end
  assign loadCommutationActive = lcOn; // R9

  ////////////////////////////////////////////////////////////////////////////////
  // Switch synchroniser: three stages, change taken once stages two and three agree
  rtsl_pkg::rtsl_sw_t sw1Ff, sw2Ff, sw3Ff, swStFf;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sw1Ff  <= '0;
      sw2Ff  <= '0;
      sw3Ff  <= '0;
      swStFf <= '0;
    end else begin
      sw1Ff <= '{left: refLeftPin, right: refRightPin};
      sw2Ff <= sw1Ff;
      sw3Ff <= sw2Ff;
      if (sw2Ff.left == sw3Ff.left)   swStFf.left  <= sw3Ff.left;
      if (sw2Ff.right == sw3Ff.right) swStFf.right <= sw3Ff.right;
    end
  end
  wire lActNow = sw3Ff.left  ^ swCfgFf[`RTSL_SW_POLL];
  wire rActNow = sw3Ff.right ^ swCfgFf[`RTSL_SW_POLR];
  wire lActOld = swStFf.left  ^ swCfgFf[`RTSL_SW_POLL];
  wire rActOld = swStFf.right ^ swCfgFf[`RTSL_SW_POLR];
  wire lChg    = (sw2Ff.left == sw3Ff.left) && (sw3Ff.left != swStFf.left);
  wire rChg    = (sw2Ff.right == sw3Ff.right) && (sw3Ff.right != swStFf.right);
  wire latchL  = lChg && ((lActNow && !lActOld && swCfgFf[`RTSL_SW_LAT_LA]) ||
                          (!lActNow && lActOld && swCfgFf[`RTSL_SW_LAT_LI]));
  wire latchR  = rChg && ((rActNow && !rActOld && swCfgFf[`RTSL_SW_LAT_RA]) ||
                          (!rActNow && rActOld && swCfgFf[`RTSL_SW_LAT_RI]));

  // Position latches and status flags; a new event beats a same-cycle clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      latchFf    <= 32'h0;
      encLatchFf <= 32'h0;
      latStatFf  <= 2'h0;
      posStatFf  <= 1'b0;
      reachedFf  <= 1'b0;
    end else begin
      if (latchL || latchR) begin
        latchFf <= curPosFf; // R14
        if (swCfgFf[`RTSL_SW_ENCLAT]) encLatchFf <= encoderPosition; // R15
      end
      latStatFf[0] <= latchL | (latStatFf[0] & ~(wrStat & wb_dat_i[`RTSL_ST_LATL])); // R16
      latStatFf[1] <= latchR | (latStatFf[1] & ~(wrStat & wb_dat_i[`RTSL_ST_LATR])); // R16
      reachedFf    <= atTarget && velFf == 23'h0 && modeFf == rtsl_pkg::RTSL_POSITION; // R20
      posStatFf    <= (atTarget && velFf == 23'h0 && !reachedFf) |
                      (posStatFf & ~(wrStat & wb_dat_i[`RTSL_ST_POSREACH])); // R16
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux and answer; write-only parameters read as zero
  logic [13:0] statWord;
  always_comb begin
    statWord = 14'h0;
    statWord[`RTSL_ST_LATL]       = latStatFf[0];
    statWord[`RTSL_ST_LATR]       = latStatFf[1];
    statWord[`RTSL_ST_POSREACH]   = posStatFf;
    statWord[`RTSL_ST_ZWAIT]      = (stateFf == rtsl_pkg::RTSL_ZWAIT);
    statWord[`RTSL_ST_REACHED]    = reachedFf;
    statWord[`RTSL_ST_STANDSTILL] = (velFf == 23'h0);
  end
  wire [31:0] sVel = dirFf ? (32'h0 - {9'h0, velFf}) : {9'h0, velFf};
  wire [31:0] rdMux =
    (regIdx == `RTSL_IDX_MODE)     ? {30'h0, modeFf} :
    (regIdx == `RTSL_IDX_CURPOS)   ? curPosFf :
    (regIdx == `RTSL_IDX_ACTVEL)   ? {{8{sVel[23]}}, sVel[23:0]} :
    (regIdx == `RTSL_IDX_TARGET)   ? targetFf :
    (regIdx == `RTSL_IDX_SWCFG)    ? {20'h0, swCfgFf} :
    (regIdx == `RTSL_IDX_STAT)     ? {18'h0, statWord} : // R16
    (regIdx == `RTSL_IDX_LATCH)    ? latchFf :
    (regIdx == `RTSL_IDX_ENCLATCH) ? encLatchFf :
    32'h0; // R21
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ackFf    <= 1'b0;
      rdDataFf <= 32'h0;
    end else begin
      ackFf    <= busReq;
      rdDataFf <= rdMux;
    end
  end
  assign wb_ack_o = ackFf;
  assign wb_dat_o = rdDataFf;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  stop_reset_a: assert property (@(posedge clk) $fell(reset) |-> stopVelFf == 18'h1) // R1
    else $error("stop velocity reset value wrong");
  zwait_len_a: assert property (@(posedge clk) disable iff (reset)
    $rose(stateFf == rtsl_pkg::RTSL_ZWAIT) |-> waitCntFf == {$past(zWaitFf), 9'h0}) // R4
    else $error("zero wait length wrong");
  zwait_hold_a: assert property (@(posedge clk) disable iff (reset)
    stateFf == rtsl_pkg::RTSL_ZWAIT && waitCntFf != 26'h0 |=> stateFf == rtsl_pkg::RTSL_ZWAIT) // R4
    else $error("left wait early");
  target_go_a: assert property (@(posedge clk) disable iff (reset)
    stateFf == rtsl_pkg::RTSL_IDLE && modeFf == rtsl_pkg::RTSL_POSITION && !atTarget
    |=> stateFf == rtsl_pkg::RTSL_ACCEL) // R5
    else $error("move not started");
  lc_off_a: assert property (@(posedge clk) disable iff (reset)
    lcMinFf == 23'h0 |-> !loadCommutationActive) // R10
    else $error("load commutation with zero minimum");
  latch_cap_a: assert property (@(posedge clk) disable iff (reset)
    (latchL || latchR) |=> latchFf == $past(curPosFf)) // R14
    else $error("latch missed");
  stat_set_a: assert property (@(posedge clk) disable iff (reset)
    latchL |=> statWord[`RTSL_ST_LATL]) // R16
    else $error("latch flag lost");
  ack_one_a: assert property (@(posedge clk) disable iff (reset)
    wb_ack_o |=> !wb_ack_o) // R21
    else $error("ack held");
  move_cv: cover property (@(posedge clk) stateFf == rtsl_pkg::RTSL_DECEL ##1 stateFf == rtsl_pkg::RTSL_ZWAIT);
  latch_cv: cover property (@(posedge clk) latchR);
  lc_cv: cover property (@(posedge clk) loadCommutationActive);
endmodule
